// ===== rtl/nand_host_map.svh
`ifndef NAND_HOST_MAP_SVH
`define NAND_HOST_MAP_SVH

`define NH_CLK_PERIOD_NS 10
`define NH_POWER_WAIT_US 100
`define NH_POWER_WAIT_CYC \
  ((`NH_POWER_WAIT_US * 1000 + `NH_CLK_PERIOD_NS - 1) / `NH_CLK_PERIOD_NS)
`define NH_STROBE_TO_BUSY_DELAY_NS 100
`define NH_WB_CYC \
  ((`NH_STROBE_TO_BUSY_DELAY_NS + `NH_CLK_PERIOD_NS - 1) / `NH_CLK_PERIOD_NS)
`define NH_ADDR_TO_DATA_NS 70
`define NH_ADL_CYC \
  ((`NH_ADDR_TO_DATA_NS + `NH_CLK_PERIOD_NS - 1) / `NH_CLK_PERIOD_NS)
`define NH_READ_TO_WRITE_NS 100
`define NH_RHW_CYC \
  ((`NH_READ_TO_WRITE_NS + `NH_CLK_PERIOD_NS - 1) / `NH_CLK_PERIOD_NS)
`define NH_WAIT_W 14

`define NH_PARTIAL_PROGRAM_LIMIT 3'h4
`define NH_LAST_COLUMN 12'h83f
`define NH_SPARE_COLUMN 12'h800
`define NH_BLOCKS 1024
`define NH_MIN_VALID_BLOCKS 1004
`define NH_LAST_BLOCK 10'h3ff
`define NH_ERASED_BYTE 8'hff

`define NH_CMD_RESET 8'hff
`define NH_CMD_READ1 8'h00
`define NH_CMD_READ2 8'h30
`define NH_CMD_PROG1 8'h80
`define NH_CMD_PROG2 8'h10
`define NH_CMD_ERASE1 8'h60
`define NH_CMD_ERASE2 8'hd0
`define NH_LAST_ADDR_FULL 2'h3
`define NH_LAST_ADDR_ROW 2'h1

`endif

// ===== rtl/nand_host_pkg.sv
package nand_host_pkg;

  typedef enum logic [2:0] {
    OP_RESET = 3'h0,
    OP_READ = 3'h1,
    OP_PROGRAM = 3'h2,
    OP_ERASE = 3'h3,
    OP_SCAN = 3'h4
  } op_t;

  typedef enum logic [3:0] {
    ST_POWER = 4'h0,
    ST_IDLE = 4'h1,
    ST_CMD1 = 4'h3,
    ST_ADDR = 4'h2,
    ST_GAP = 4'h6,
    ST_WDATA = 4'h7,
    ST_CMD2 = 4'h5,
    ST_WB = 4'h4,
    ST_BUSY = 4'hc,
    ST_RDATA = 4'hd,
    ST_DONE = 4'hf
  } state_t;

endpackage

// ===== rtl/wait_counter.sv
`timescale 1ns/1ps
`default_nettype none

module wait_counter #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned INIT = 0
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] value,
  output logic expired
);

  logic [WIDTH-1:0] count;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count <= WIDTH'(INIT);
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - WIDTH'(1);
    end
  end

  assign expired = (count == '0);

endmodule // wait_counter

`default_nettype wire

// ===== rtl/nand_host.sv
// How it works
// - First command is reset, after ready or wait.
// - No command within 100 ns of the last read strobe.
// - At most four partial programs per page, counted for the latest page only.
// - Last data byte lands at column 2111.
// - Scan every marker into a table first.
// - Never erase before markers are recorded.
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_map.svh"

module nand_host #(
  parameter int unsigned POWER_WAIT_CYC = `NH_POWER_WAIT_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic ready_busy_out,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe,
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic wp_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire nand_host_pkg::op_t cmd_op,
  input wire logic [9:0] cmd_block,
  input wire logic [5:0] cmd_page,
  input wire logic [11:0] cmd_col,
  input wire logic [11:0] cmd_len,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic error,
  output logic scan_done,
  output logic scan_fault,
  output logic [10:0] bad_count
);

  localparam int WB_MIN = `NH_WB_CYC;

  nand_host_pkg::state_t state;
  nand_host_pkg::op_t op;
  logic [1:0] phase;
  logic [1:0] addr_idx;
  logic [11:0] cnt;
  logic [9:0] block;
  logic [5:0] page;
  logic [11:0] col;
  logic [11:0] len;
  logic [15:0] pp_page;
  logic [2:0] pp_count;
  logic bad_tbl [0:`NH_BLOCKS-1];

  wire cmd_take = cmd_valid && cmd_ready;
  wire wr_take = wr_valid && wr_ready;
  wire cycle_end = (phase == 2'h3);
  wire is_prog = (cmd_op == nand_host_pkg::OP_PROGRAM);
  wire is_erase = (cmd_op == nand_host_pkg::OP_ERASE);
  wire is_read = (cmd_op == nand_host_pkg::OP_READ);
  wire [12:0] last_col = {1'b0, cmd_col} + {1'b0, cmd_len} - 13'h1;
  wire len_ok = (cmd_len != 12'h0) && (last_col <= {1'b0, `NH_LAST_COLUMN});
  wire pp_hit = ({cmd_block, cmd_page} == pp_page);
  wire pp_full = pp_hit && (pp_count == `NH_PARTIAL_PROGRAM_LIMIT);
  wire blk_bad = bad_tbl[cmd_block];
  // Program and erase need the marker table, so both wait for the scan.
  wire refuse_wr = (is_prog || is_erase) && (!scan_done || blk_bad);
  wire refuse = refuse_wr || ((is_prog || is_read) && !len_ok) ||
    (is_prog && pp_full) ||
    (cmd_op == nand_host_pkg::OP_SCAN) || (cmd_op > nand_host_pkg::OP_SCAN);

  wire [15:0] row = {block, page};
  wire [1:0] last_addr = (op == nand_host_pkg::OP_ERASE) ?
    `NH_LAST_ADDR_ROW : `NH_LAST_ADDR_FULL;
  wire [1:0] addr_sel = (op == nand_host_pkg::OP_ERASE) ?
    addr_idx + 2'h2 : addr_idx;
  wire [7:0] addr_byte = (addr_sel == 2'h0) ? col[7:0] :
    (addr_sel == 2'h1) ? {4'h0, col[11:8]} :
    (addr_sel == 2'h2) ? row[7:0] : row[15:8];
  wire [7:0] cmd1_byte = (op == nand_host_pkg::OP_RESET) ? `NH_CMD_RESET :
    (op == nand_host_pkg::OP_PROGRAM) ? `NH_CMD_PROG1 :
    (op == nand_host_pkg::OP_ERASE) ? `NH_CMD_ERASE1 : `NH_CMD_READ1;
  wire [7:0] cmd2_byte = (op == nand_host_pkg::OP_PROGRAM) ? `NH_CMD_PROG2 :
    (op == nand_host_pkg::OP_ERASE) ? `NH_CMD_ERASE2 : `NH_CMD_READ2;
  wire [7:0] byte_sel = (state == nand_host_pkg::ST_CMD1) ? cmd1_byte :
    (state == nand_host_pkg::ST_CMD2) ? cmd2_byte :
    (state == nand_host_pkg::ST_ADDR) ? addr_byte : wr_data;

  wire st_write = (state == nand_host_pkg::ST_CMD1) ||
    (state == nand_host_pkg::ST_ADDR) || (state == nand_host_pkg::ST_CMD2) ||
    (state == nand_host_pkg::ST_WDATA);
  wire st_read = (state == nand_host_pkg::ST_RDATA);
  wire phase_run = (st_write && state != nand_host_pkg::ST_WDATA) ||
    st_read || (state == nand_host_pkg::ST_WDATA &&
    (phase != 2'h0 || wr_take));
  wire load_byte = (phase == 2'h0) &&
    ((st_write && state != nand_host_pkg::ST_WDATA) || wr_take);
  wire strobe_low = (st_write || st_read) &&
    (phase == 2'h1 || phase == 2'h2);
  wire mark_bad = st_read && cycle_end &&
    (op == nand_host_pkg::OP_SCAN) && (io_in != `NH_ERASED_BYTE);
  wire read_last = st_read && cycle_end && (cnt == len - 12'h1);

  wire wb_enter = cycle_end && ((state == nand_host_pkg::ST_CMD2) ||
    (state == nand_host_pkg::ST_CMD1 && op == nand_host_pkg::OP_RESET));
  wire adl_enter = cycle_end && (state == nand_host_pkg::ST_ADDR) &&
    (addr_idx == last_addr) && (op == nand_host_pkg::OP_PROGRAM);
  wire wait_load = wb_enter || adl_enter || read_last;
  wire [`NH_WAIT_W-1:0] wait_value = wb_enter ? `NH_WAIT_W'(`NH_WB_CYC) :
    adl_enter ? `NH_WAIT_W'(`NH_ADL_CYC) : `NH_WAIT_W'(`NH_RHW_CYC);
  wire wait_expired;

  wait_counter #(
    .WIDTH(`NH_WAIT_W),
    .INIT(POWER_WAIT_CYC)
  ) u_wait (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .load(wait_load),
    .value(wait_value),
    .expired(wait_expired)
  );

  // Pins are registered one cycle behind the sequencer phase.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ce_n <= 1'b1;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_oe <= 1'b0;
      io_out <= 8'h00;
      wp_n <= 1'b0;
    end else begin
      ce_n <= (state == nand_host_pkg::ST_POWER) ||
        (state == nand_host_pkg::ST_IDLE);
      cle <= (state == nand_host_pkg::ST_CMD1) ||
        (state == nand_host_pkg::ST_CMD2);
      ale <= (state == nand_host_pkg::ST_ADDR);
      we_n <= !(st_write && strobe_low);
      re_n <= !(st_read && strobe_low);
      io_oe <= st_write;
      wp_n <= (state != nand_host_pkg::ST_POWER);
      if (load_byte) io_out <= byte_sel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < `NH_BLOCKS; i++) bad_tbl[i] <= 1'b0;
      bad_count <= 11'h000;
      scan_fault <= 1'b0;
    end else begin
      if (mark_bad) bad_tbl[block] <= 1'b1;
      if (mark_bad && !bad_tbl[block]) bad_count <= bad_count + 11'h001;
      scan_fault <= bad_count > 11'(`NH_BLOCKS - `NH_MIN_VALID_BLOCKS);
    end
  end

  // Only the latest programmed page is tracked; pages go in order anyway.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pp_page <= 16'h0000;
      pp_count <= 3'h0;
    end else if (cmd_take && !refuse && is_prog) begin
      pp_page <= {cmd_block, cmd_page};
      pp_count <= pp_hit ? pp_count + 3'h1 : 3'h1;
    end else if (cmd_take && !refuse && is_erase &&
                 cmd_block == pp_page[15:6]) begin
      pp_count <= 3'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      phase <= 2'h0;
      cnt <= 12'h000;
    end else begin
      phase <= phase_run ? phase + 2'h1 : 2'h0;
      if (state == nand_host_pkg::ST_GAP || state == nand_host_pkg::ST_BUSY)
        cnt <= 12'h000;
      else if (cycle_end && (st_read || state == nand_host_pkg::ST_WDATA))
        cnt <= cnt + 12'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= nand_host_pkg::ST_POWER;
      op <= nand_host_pkg::OP_RESET;
      addr_idx <= 2'h0;
      {block, page, col, len} <= 40'h0;
      {cmd_ready, wr_ready, rd_valid, done, error, scan_done} <= 6'h00;
      rd_data <= 8'h00;
    end else begin
      done <= 1'b0;
      error <= 1'b0;
      rd_valid <= 1'b0;
      case (state)
        nand_host_pkg::ST_POWER: begin
          if (wait_expired || ready_busy_out) begin
            state <= nand_host_pkg::ST_CMD1;
            op <= nand_host_pkg::OP_RESET;
          end
        end
        nand_host_pkg::ST_IDLE: begin
          cmd_ready <= !cmd_take;
          if (cmd_take && refuse) begin
            error <= 1'b1;
          end else if (cmd_take) begin
            state <= nand_host_pkg::ST_CMD1;
            op <= cmd_op;
            {block, page, col, len} <= {cmd_block, cmd_page, cmd_col, cmd_len};
          end
        end
        nand_host_pkg::ST_CMD1: begin
          addr_idx <= 2'h0;
          if (cycle_end) state <= (op == nand_host_pkg::OP_RESET) ?
            nand_host_pkg::ST_WB : nand_host_pkg::ST_ADDR;
        end
        nand_host_pkg::ST_ADDR: begin
          if (cycle_end) begin
            addr_idx <= addr_idx + 2'h1;
            if (addr_idx == last_addr)
              state <= (op == nand_host_pkg::OP_PROGRAM) ?
                nand_host_pkg::ST_GAP : nand_host_pkg::ST_CMD2;
          end
        end
        nand_host_pkg::ST_GAP: begin
          if (wait_expired) state <= nand_host_pkg::ST_WDATA;
        end
        nand_host_pkg::ST_WDATA: begin
          wr_ready <= (phase == 2'h0) && !wr_take;
          if (cycle_end && cnt == len - 12'h1)
            state <= nand_host_pkg::ST_CMD2;
        end
        nand_host_pkg::ST_CMD2: begin
          if (cycle_end) state <= nand_host_pkg::ST_WB;
        end
        nand_host_pkg::ST_WB: begin
          // The busy pin is not trusted until the strobe-to-busy gap ends.
          if (wait_expired) state <= nand_host_pkg::ST_BUSY;
        end
        nand_host_pkg::ST_BUSY: begin
          if (ready_busy_out)
            state <= (op == nand_host_pkg::OP_READ ||
              op == nand_host_pkg::OP_SCAN) ?
              nand_host_pkg::ST_RDATA : nand_host_pkg::ST_DONE;
        end
        nand_host_pkg::ST_RDATA: begin
          if (cycle_end) begin
            rd_data <= io_in;
            rd_valid <= (op == nand_host_pkg::OP_READ);
          end
          if (read_last) state <= nand_host_pkg::ST_DONE;
        end
        nand_host_pkg::ST_DONE: begin
          if (wait_expired) begin
            if (op == nand_host_pkg::OP_SCAN && page == 6'h00) begin
              page <= 6'h01;
              state <= nand_host_pkg::ST_CMD1;
            end else if (op == nand_host_pkg::OP_SCAN &&
                         block != `NH_LAST_BLOCK) begin
              block <= block + 10'h001;
              page <= 6'h00;
              state <= nand_host_pkg::ST_CMD1;
            end else if (op == nand_host_pkg::OP_RESET && !scan_done) begin
              op <= nand_host_pkg::OP_SCAN;
              {block, page} <= 16'h0000;
              col <= `NH_SPARE_COLUMN;
              len <= 12'h001;
              state <= nand_host_pkg::ST_CMD1;
            end else begin
              scan_done <= 1'b1;
              done <= scan_done;
              state <= nand_host_pkg::ST_IDLE;
            end
          end
        end
        default: state <= nand_host_pkg::ST_POWER;
      endcase
    end
  end

  logic [7:0] wb_len;
  always_ff @(posedge core_clk) begin
    if (!reset_n) wb_len <= 8'h00;
    else if (state == nand_host_pkg::ST_WB) wb_len <= wb_len + 8'h01;
    else wb_len <= 8'h00;
  end

  a_first_reset: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(state) == nand_host_pkg::ST_POWER && state != nand_host_pkg::ST_POWER
    |-> op == nand_host_pkg::OP_RESET ##[1:8] cle && io_out == `NH_CMD_RESET)
    else $error("First command after power-up is not a reset.");
  a_wb_gap: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(state) == nand_host_pkg::ST_WB && state != nand_host_pkg::ST_WB
    |-> wb_len > WB_MIN)
    else $error("Strobe-to-busy gap cut short.");
  // Pins lag the state by one cycle, so the first gap cycle still shows cle.
  a_wb_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
    state == nand_host_pkg::ST_WB && $past(state) == nand_host_pkg::ST_WB
    |-> we_n && !cle && !ale && re_n)
    else $error("Strobe moved during the strobe-to-busy gap.");
  a_partial_limit: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmd_take && is_prog && pp_full |=> error && state == nand_host_pkg::ST_IDLE)
    else $error("Fifth partial program of a page was issued.");
  a_last_column: assert property (@(posedge core_clk) disable iff (!reset_n)
    state == nand_host_pkg::ST_WDATA && cycle_end
    |-> {1'b0, col} + {1'b0, cnt} <= {1'b0, `NH_LAST_COLUMN})
    else $error("Data loaded past the last column.");
  a_scan_first: assert property (@(posedge core_clk) disable iff (!reset_n)
    state == nand_host_pkg::ST_CMD1 && op == nand_host_pkg::OP_PROGRAM
    |-> scan_done && !bad_tbl[block])
    else $error("Program issued before or against the marker table.");
  a_erase_guard: assert property (@(posedge core_clk) disable iff (!reset_n)
    state == nand_host_pkg::ST_CMD1 && op == nand_host_pkg::OP_ERASE
    |-> scan_done && !bad_tbl[block])
    else $error("Erase issued before markers were recorded.");
  c_scan_end: cover property (@(posedge core_clk) disable iff (!reset_n)
    $rose(scan_done));
  c_program_done: cover property (@(posedge core_clk) disable iff (!reset_n)
    done && op == nand_host_pkg::OP_PROGRAM);
  c_refused: cover property (@(posedge core_clk) disable iff (!reset_n)
    error);

endmodule // nand_host

`default_nettype wire

// ===== verification/nand_device_model.sv
`timescale 1ns/1ps
`default_nettype none
module nand_device_model #(
  parameter int POWER_CYC = 15,
  parameter int BUSY_CYC = 6,
  parameter int PROG_CYC = 30,
  parameter int FIRST_RESET_CYC = 40
) (
  input wire logic core_clk,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic io_oe,
  input wire logic [7:0] io_out,
  output logic [7:0] io_in,
  output logic ready_busy_out
);
  logic [7:0] mem [logic [27:0]];
  logic [7:0] last = 8'h5a;
  logic [15:0] row = 16'h0000;
  logic [11:0] col = 12'h000;
  int n_addr = 0;
  int viol = 0;
  bit armed = 0;
  realtime gap_end = 0;

  function automatic logic [7:0] rd(input logic [27:0] k);
    return mem.exists(k) ? mem[k] : 8'hff;
  endfunction

  task automatic go_busy(input int n);
    gap_end = $realtime + 100.0;
    fork begin
      // The pin moves between clock edges so the host never samples a race.
      #32;
      ready_busy_out = 1'b0;
      repeat (n) @(negedge core_clk);
      ready_busy_out = 1'b1;
    end join_none
  endtask

  task automatic erase_block();
    logic [27:0] q [$];
    foreach (mem[k])
      if (k[27:18] == row[15:6]) q.push_back(k);
    foreach (q[i]) mem.delete(q[i]);
  endtask

  // Only two blocks carry a marker and block zero stays clean.
  initial begin
    io_in = 8'ha5;
    ready_busy_out = 1'b0;
    mem[{10'h005, 6'h00, 12'h800}] = 8'h00;
    mem[{10'h3ff, 6'h01, 12'h800}] = 8'h3c;
    repeat (POWER_CYC) @(negedge core_clk);
    ready_busy_out = 1'b1;
  end

  always @(negedge we_n)
    if (ce_n === 1'b0 && (!ready_busy_out || $realtime < gap_end))
      viol++;

  always @(posedge we_n) begin
    if (ce_n !== 1'b0) begin
    end else if (cle) begin
      if (io_out != 8'hff && !armed) viol++;
      if (io_out inside {8'h10, 8'hd0} && !wp_n) viol++;
      n_addr = (io_out == 8'h60) ? 2 : 0;
      if (io_out == 8'hd0) erase_block();
      if (io_out == 8'h30) go_busy(BUSY_CYC);
      // Program and erase outlast the strobe gap, so the host must wait.
      if (io_out inside {8'h10, 8'hd0}) go_busy(PROG_CYC);
      if (io_out == 8'hff) go_busy(armed ? BUSY_CYC : FIRST_RESET_CYC);
      if (io_out == 8'hff) armed = 1;
    end else if (ale) begin
      case (n_addr)
        0: col[7:0] = io_out;
        1: col[11:8] = io_out[3:0];
        2: row[7:0] = io_out;
        default: row[15:8] = io_out;
      endcase
      n_addr++;
    end else begin
      mem[{row, col}] = rd({row, col}) & io_out;
      col++;
    end
  end

  always @(negedge re_n)
    if (ce_n === 1'b0) begin
      if (io_oe) viol++;
      #15;
      last = rd({row, col});
      io_in = last;
      col++;
    end

  // A released bus shows the inverse, so a late sample cannot pass by luck.
  always @(posedge re_n) begin
    #15;
    io_in = ~last;
  end
endmodule // nand_device_model
`default_nettype wire

// ===== verification/nand_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
module nand_host_bench;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic [9:0] cmd_block = 10'h000;
  logic [5:0] cmd_page = 6'h00;
  logic [11:0] cmd_col = 12'h000;
  logic [11:0] cmd_len = 12'h001;
  nand_host_pkg::op_t cmd_op = nand_host_pkg::OP_RESET;
  logic ready_busy_out, io_oe, ce_n, cle, ale, we_n, re_n, wp_n;
  logic cmd_ready, wr_ready, rd_valid, done, error, scan_done, scan_fault;
  logic [7:0] io_in, io_out, rd_data;
  logic [10:0] bad_count;
  logic taken = 1'b0;
  logic [1:0] res;
  logic [7:0] got [$];
  int err_total = 0;
  int compares = 0;
  int cycles = 0;

  nand_host #(.POWER_WAIT_CYC(20)) dut (
    .core_clk, .reset_n, .ready_busy_out, .io_in, .io_out, .io_oe,
    .ce_n, .cle, .ale, .we_n, .re_n, .wp_n, .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_block, .cmd_page, .cmd_col, .cmd_len, .wr_data,
    .wr_valid, .wr_ready, .rd_data, .rd_valid, .done, .error,
    .scan_done, .scan_fault, .bad_count
  );
  nand_device_model flash (
    .core_clk, .ce_n, .cle, .ale, .we_n, .re_n, .wp_n, .io_oe, .io_out,
    .io_in, .ready_busy_out
  );

  always #5 core_clk = ~core_clk;

  task automatic conclude();
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] a, input logic [31:0] b);
    compares++;
    if (a !== b) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, a, b);
    end
  endtask

  // The full marker scan dominates the run, so the ceiling sits above it.
  always @(posedge core_clk) begin
    cycles++;
    taken <= wr_valid && wr_ready;
    if (cycles == 120000) begin
      err_total++;
      conclude();
    end
  end

  always @(negedge core_clk) begin
    if (taken) wr_data = wr_data + 8'h11;
    if (rd_valid === 1'b1) got.push_back(rd_data);
    if (done === 1'b1) check(ready_busy_out, 1'b1);
  end

  task automatic issue(input logic [2:0] op, input logic [9:0] blk,
      input logic [5:0] pg, input logic [11:0] col, input logic [11:0] len,
      input logic [7:0] first);
    int n;
    n = 0;
    got.delete();
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    cmd_op = nand_host_pkg::op_t'(op);
    cmd_block = blk;
    cmd_page = pg;
    cmd_col = col;
    cmd_len = len;
    wr_data = first;
    cmd_valid = 1'b1;
    wr_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && error !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    res = {done, error};
    wr_valid = 1'b0;
  endtask

  task automatic t_scan();
    int n;
    n = 0;
    while (scan_done !== 1'b1 && n < 110000) begin
      @(negedge core_clk);
      n++;
    end
    check(bad_count, 11'h002);
    check(scan_fault, 1'b0);
  endtask

  task automatic t_last_column();
    issue(3'h2, 10'h000, 6'h00, 12'h83f, 12'h001, 8'ha5);
    check(res, 2'b10);
    issue(3'h1, 10'h000, 6'h00, 12'h83f, 12'h001, 8'h00);
    check(got[0], 8'ha5);
    issue(3'h2, 10'h000, 6'h01, 12'h83f, 12'h002, 8'h00);
    check(res, 2'b01);
  endtask

  task automatic t_bad_blocks();
    issue(3'h2, 10'h005, 6'h00, 12'h000, 12'h001, 8'h12);
    check(res, 2'b01);
    issue(3'h3, 10'h3ff, 6'h00, 12'h000, 12'h001, 8'h00);
    check(res, 2'b01);
    issue(3'h1, 10'h005, 6'h00, 12'h800, 12'h001, 8'h00);
    check(got[0], 8'h00);
    issue(3'h2, 10'h006, 6'h00, 12'h000, 12'h004, 8'h30);
    check(res, 2'b10);
    issue(3'h1, 10'h006, 6'h00, 12'h000, 12'h004, 8'h00);
    for (int i = 0; i < 4; i++)
      check(got[i], 8'h30 + 8'h11 * i);
  endtask

  task automatic t_partial();
    for (int i = 0; i < 5; i++) begin
      issue(3'h2, 10'h002, 6'h03, 12'h010, 12'h001, 8'hf0);
      check(res, (i < 4) ? 2'b10 : 2'b01);
    end
    issue(3'h3, 10'h002, 6'h00, 12'h000, 12'h001, 8'h00);
    check(res, 2'b10);
    issue(3'h2, 10'h002, 6'h03, 12'h010, 12'h001, 8'h0f);
    check(res, 2'b10);
    issue(3'h1, 10'h002, 6'h03, 12'h010, 12'h001, 8'h00);
    check(got[0], 8'h0f);
  endtask

  task automatic t_misc();
    for (int op = 4; op < 8; op++) begin
      issue(op[2:0], 10'h001, 6'h00, 12'h000, 12'h001, 8'h00);
      check(res, 2'b01);
    end
    issue(3'h1, 10'h001, 6'h00, 12'h000, 12'h000, 8'h00);
    check(res, 2'b01);
    issue(3'h0, 10'h000, 6'h00, 12'h000, 12'h001, 8'h00);
    check(res, 2'b10);
  endtask

  initial begin
    repeat (3) @(negedge core_clk);
    check({wp_n, ce_n, we_n}, 3'h3);
    reset_n = 1'b1;
    t_scan();
    t_last_column();
    t_bad_blocks();
    t_partial();
    t_misc();
    check(flash.viol, 0);
    conclude();
  end
endmodule // nand_host_bench
`default_nettype wire
